// file: rtl/i2c_config_guard.sv
// two-wire target port with write protection for config and memory bytes
//
// Behaviour
// - protection code resets to fully protected
// - config and memory protection kept separately
// - code 55 unlocks config and memory
// - 59 unlocks config only, 35 memory only
// - any other code relocks that region
// - protect pin blocks all config, memory writes
// - programmed lock bit freezes configuration bytes
// - three-state straps give 21 addresses
// - sample on rising, change after falling
// - bytes travel most significant bit first
// - data held steady while clock high
// - eight bits then receiver acknowledge slot
// - falling data start, rising data stop
// - address byte: type, bus address, direction
// - one device type for all regions
// - device type also follows strap setting
// - answer only own strap bus address
// - protection code decoded nibble by nibble
// - write-only protection code at pointer 38
// - page of sixteen bytes, committed at stop
// - pointer write, repeated start, read until nack
`timescale 1ns/1ps
`default_nettype none
module i2c_config_guard (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic SCL_CLK,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic WRITE_PROT,
	input wire logic [1:0] STRAP_SELECT_HI,
	input wire logic [1:0] STRAP_SELECT_MID,
	input wire logic [1:0] STRAP_SELECT_LO,
	output logic WRITE_BUSY,
	output logic ADDR_READY
);

	////////////////////////////////////////////////////////////////////////
	// shared storage and strap capture

	store_if st_bus(); // carrier to the byte store
	logic [6:0] dev_addr; // decoded type and bus address
	logic addr_valid; // address captured (system clock)

	nv_store u_store (
		.clk(CLK),
		.resetn(RESETN),
		.st(st_bus)
	);

	strap_capture u_strap (
		.clk(CLK),
		.resetn(RESETN),
		.sel_hi(STRAP_SELECT_HI),
		.sel_mid(STRAP_SELECT_MID),
		.sel_lo(STRAP_SELECT_LO),
		.dev_addr(dev_addr),
		.addr_valid(addr_valid)
	);

	////////////////////////////////////////////////////////////////////////
	// start and stop detection, clocked by the data line itself

	logic start_tog; // flips on every start
	logic stop_tog; // flips on every stop

	// falling data while the clock is high marks a start
	always_ff @(negedge SDA_IN or negedge RESETN) begin
		if (!RESETN) begin
			start_tog <= 1'h0;
		end else if (SCL_CLK) begin
			start_tog <= ~start_tog;
		end
	end

	// rising data while the clock is high marks a stop
	always_ff @(posedge SDA_IN or negedge RESETN) begin
		if (!RESETN) begin
			stop_tog <= 1'h0;
		end else if (SCL_CLK) begin
			stop_tog <= ~stop_tog;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link domain (serial clock)

	guard_pkg::link_state_t state; // frame position
	logic [3:0] bitcnt; // clock within the current byte
	logic [7:0] shreg; // receive shifter
	logic start_seen; // start toggle already acted on
	logic ack_go; // drive acknowledge in the ninth slot
	logic [7:0] ptr; // internal address pointer
	logic [7:0] rd_byte; // byte being returned
	logic [7:0] prot_q; // volatile protection code
	logic [7:0] page_buf [16]; // bytes of one page write
	logic [7:0] page_base; // pointer of the first buffered byte
	logic [4:0] page_cnt; // buffered byte count
	logic v1, v2, v3; // address-valid synchroniser
	logic link_valid; // address usable on the link side
	logic start_evt; // first rising clock after a start
	logic rx_done; // eighth bit is being sampled now
	logic [7:0] rx_byte; // byte completed on this edge
	logic addr_match; // address byte is for this device

	assign start_evt = start_tog ^ start_seen;
	assign rx_done = !start_evt && bitcnt == guard_pkg::LAST_BIT;
	assign rx_byte = {shreg[6:0], SDA_IN};
	// one type for every region; type and bus both come from straps
	assign addr_match = link_valid && rx_byte[7:1] == dev_addr;
	assign link_valid = v2 && v3;
	assign st_bus.rd_addr = ptr;

	// address-valid crossing; valid counts once stages two and three are both set
	always_ff @(posedge SCL_CLK or negedge RESETN) begin
		if (!RESETN) begin
			v1 <= 1'h0;
			v2 <= 1'h0;
			v3 <= 1'h0;
		end else begin
			v1 <= addr_valid;
			v2 <= v1;
			v3 <= v2;
		end
	end

	// receive shifter and start acknowledge
	always_ff @(posedge SCL_CLK or negedge RESETN) begin
		if (!RESETN) begin
			shreg <= 8'h00;
			start_seen <= 1'h0;
		end else begin
			start_seen <= start_tog;
			shreg <= start_evt ? {7'h00, SDA_IN} : rx_byte;
		end
	end

	// frame sequencing: eight data clocks then one acknowledge clock
	always_ff @(posedge SCL_CLK or negedge RESETN) begin
		if (!RESETN) begin
			state <= guard_pkg::S_IDLE;
			bitcnt <= 4'h0;
		end else if (start_evt) begin
			state <= guard_pkg::S_ADDR; // repeated start lands here too
			bitcnt <= 4'h1;
		end else if (state == guard_pkg::S_IDLE ||
			state == guard_pkg::S_IGNORE) begin
			bitcnt <= 4'h0; // wait for the next start
		end else if (bitcnt == guard_pkg::ACK_SLOT) begin
			bitcnt <= 4'h0;
			// host leaves data high after a read byte: stop sending
			if (state == guard_pkg::S_RDATA && !ack_go && SDA_IN) begin
				state <= guard_pkg::S_IGNORE;
			end
		end else begin
			bitcnt <= bitcnt + 4'h1;
			if (rx_done) begin
				case (state)
					guard_pkg::S_ADDR: begin
						if (!addr_match) begin
							state <= guard_pkg::S_IGNORE;
						end else if (rx_byte[0]) begin
							state <= guard_pkg::S_RDATA;
						end else begin
							state <= guard_pkg::S_PTR;
						end
					end
					guard_pkg::S_PTR: begin
						state <= guard_pkg::S_WDATA;
					end
					default: begin
						state <= state; // data phases continue
					end
				endcase
			end
		end
	end

	// acknowledge decision, held from bit eight to the end of the slot
	always_ff @(posedge SCL_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ack_go <= 1'h0;
		end else if (start_evt || bitcnt == guard_pkg::ACK_SLOT) begin
			ack_go <= 1'h0;
		end else if (rx_done) begin
			case (state)
				guard_pkg::S_ADDR: ack_go <= addr_match;
				guard_pkg::S_PTR: ack_go <= 1'h1;
				guard_pkg::S_WDATA: ack_go <= 1'h1;
				default: ack_go <= 1'h0; // reads are acked by the host
			endcase
		end
	end

	// pointer: loaded by the pointer byte, stepped after each data byte
	always_ff @(posedge SCL_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ptr <= 8'h00;
		end else if (rx_done && state == guard_pkg::S_PTR) begin
			ptr <= rx_byte;
		end else if (rx_done && state == guard_pkg::S_WDATA) begin
			ptr <= {ptr[7:4], ptr[3:0] + 4'h1}; // wraps inside the page
		end else if (rx_done && state == guard_pkg::S_RDATA) begin
			ptr <= ptr + 8'h01;
		end
	end

	// read byte: loaded on address accept and on each host acknowledge
	always_ff @(posedge SCL_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rd_byte <= 8'h00;
		end else if ((rx_done && state == guard_pkg::S_ADDR && addr_match &&
			rx_byte[0]) || (bitcnt == guard_pkg::ACK_SLOT && !ack_go &&
			state == guard_pkg::S_RDATA && !SDA_IN)) begin
			// the protection code is write-only and reads back as zero
			rd_byte <= (ptr == guard_pkg::PROT_ADDR) ? 8'h00 :
				st_bus.rd_data;
		end
	end

	// protection code, volatile; reset leaves both regions locked
	always_ff @(posedge SCL_CLK or negedge RESETN) begin
		if (!RESETN) begin
			prot_q <= guard_pkg::PROT_RESET;
		end else if (rx_done && state == guard_pkg::S_WDATA &&
			ptr == guard_pkg::PROT_ADDR) begin
			prot_q <= rx_byte;
		end
	end

	// page buffer; extra bytes past sixteen are acked but dropped
	always_ff @(posedge SCL_CLK or negedge RESETN) begin
		if (!RESETN) begin
			page_cnt <= 5'h00;
			page_base <= 8'h00;
			for (int i = 0; i < 16; i++) begin
				page_buf[i] <= 8'h00;
			end
		end else if (start_evt) begin
			page_cnt <= 5'h00; // a frame without data commits nothing
		end else if (rx_done && state == guard_pkg::S_WDATA &&
			ptr != guard_pkg::PROT_ADDR &&
			page_cnt != guard_pkg::PAGE_BYTES) begin
			page_buf[page_cnt[3:0]] <= rx_byte;
			page_cnt <= page_cnt + 5'h01;
			if (page_cnt == 5'h00) begin
				page_base <= ptr;
			end
		end
	end

	// data line driver: changes only after the falling clock edge
	always_ff @(negedge SCL_CLK or negedge RESETN) begin
		if (!RESETN) begin
			SDA_OE <= 1'h0;
			SDA_OUT <= 1'h0;
		end else begin
			SDA_OUT <= 1'h0; // open drain: only ever pulls low
			if (bitcnt == guard_pkg::ACK_SLOT) begin
				SDA_OE <= ack_go;
			end else if (state == guard_pkg::S_RDATA) begin
				SDA_OE <= ~rd_byte[~bitcnt[2:0]];
			end else begin
				SDA_OE <= 1'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// system domain: crossings and the commit engine

	logic wp1, wp2, wp3, wp_s; // protect pin, three stages plus agreed
	logic [1:0] u1, u2, u3, unl_s; // unlock bits {cfg, mem}
	logic t1, t2, t3, stop_lvl; // stop toggle crossing
	logic stop_evt; // one cycle per stop
	logic [1:0] unl_link; // decoded unlock bits, link side
	logic mem_ok, cfg_ok; // region write gates
	guard_pkg::commit_state_t cstate; // commit engine state
	logic [3:0] idx; // byte being committed
	logic [4:0] ccnt; // bytes to commit
	logic [7:0] caddr; // address of byte idx

	// nibble decode: upper unlocks config, lower unlocks memory
	assign unl_link = {prot_q[7:4] == guard_pkg::UNLOCK_NIB,
		prot_q[3:0] == guard_pkg::UNLOCK_NIB};
	assign stop_evt = (t2 == t3) && (t3 != stop_lvl);
	assign mem_ok = unl_s[0] && !wp_s;
	assign cfg_ok = unl_s[1] && !wp_s && !st_bus.cfg_lock;
	assign caddr = {page_base[7:4], page_base[3:0] + idx};

	// three-stage crossings; values move only once stages two and three agree
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			{wp1, wp2, wp3, wp_s} <= 4'h0;
			{u1, u2, u3, unl_s} <= 8'h00;
			{t1, t2, t3, stop_lvl} <= 4'h0;
		end else begin
			{wp1, wp2, wp3} <= {WRITE_PROT, wp1, wp2};
			{u1, u2, u3} <= {unl_link, u1, u2};
			{t1, t2, t3} <= {stop_tog, t1, t2};
			if (wp2 == wp3) wp_s <= wp3;
			if (u2 == u3) unl_s <= u3;
			if (t2 == t3) stop_lvl <= t3;
		end
	end

	// commit engine: copies the page after stop, one byte a cycle;
	// buffer and count are quiet then because the link has ended
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cstate <= guard_pkg::C_IDLE;
			idx <= 4'h0;
			ccnt <= 5'h00;
		end else begin
			case (cstate)
				guard_pkg::C_IDLE: begin
					if (stop_evt && page_cnt != 5'h00) begin
						cstate <= guard_pkg::C_COPY;
						ccnt <= page_cnt;
						idx <= 4'h0;
					end
				end
				default: begin
					idx <= idx + 4'h1;
					if ({1'h0, idx} + 5'h01 == ccnt) begin
						cstate <= guard_pkg::C_IDLE;
					end
				end
			endcase
		end
	end

	// write strobe: gated per region; other bytes are command and status
	always_comb begin
		st_bus.wr_addr = caddr;
		st_bus.wr_data = page_buf[idx];
		st_bus.wr_en = 1'h0;
		if (cstate == guard_pkg::C_COPY) begin
			if (guard_pkg::is_mem(caddr)) begin
				st_bus.wr_en = mem_ok;
			end else if (guard_pkg::is_cfg(caddr)) begin
				st_bus.wr_en = cfg_ok;
			end else begin
				st_bus.wr_en = 1'h1;
			end
		end
	end

	// status outputs, registered
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			WRITE_BUSY <= 1'h0;
			ADDR_READY <= 1'h0;
		end else begin
			WRITE_BUSY <= (cstate == guard_pkg::C_IDLE) ?
				(stop_evt && page_cnt != 5'h00) :
				({1'h0, idx} + 5'h01 != ccnt);
			ADDR_READY <= addr_valid;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence stop_with_data;
		cstate == guard_pkg::C_IDLE && stop_evt && page_cnt != 5'h00;
	endsequence

	sequence copy_runs;
		cstate == guard_pkg::C_COPY && WRITE_BUSY;
	endsequence

	commit_on_stop_a: assert property (@(posedge CLK)
		disable iff (!RESETN) stop_with_data |=> copy_runs)
		else $error("page not committed after stop");

	mem_gate_a: assert property (@(posedge CLK) disable iff (!RESETN)
		st_bus.wr_en && guard_pkg::is_mem(st_bus.wr_addr) |-> unl_s[0])
		else $error("memory written while locked");

	cfg_gate_a: assert property (@(posedge CLK) disable iff (!RESETN)
		st_bus.wr_en && guard_pkg::is_cfg(st_bus.wr_addr) |-> unl_s[1])
		else $error("config written while locked");

	pin_block_a: assert property (@(posedge CLK) disable iff (!RESETN)
		wp_s |-> !(st_bus.wr_en && (guard_pkg::is_mem(st_bus.wr_addr) ||
		guard_pkg::is_cfg(st_bus.wr_addr))))
		else $error("write passed the protect pin");

	lock_block_a: assert property (@(posedge CLK) disable iff (!RESETN)
		st_bus.cfg_lock |-> !(st_bus.wr_en && guard_pkg::is_cfg(st_bus.wr_addr)))
		else $error("config written after lock");

	prot_write_a: assert property (@(posedge SCL_CLK)
		disable iff (!RESETN) rx_done && state == guard_pkg::S_WDATA &&
		ptr == guard_pkg::PROT_ADDR |=> prot_q == $past(rx_byte))
		else $error("protection code not stored");

	addr_ignore_a: assert property (@(posedge SCL_CLK)
		disable iff (!RESETN) rx_done && state == guard_pkg::S_ADDR &&
		!addr_match |=> state == guard_pkg::S_IGNORE ##1 !SDA_OE)
		else $error("foreign address answered");

	ack_drive_a: assert property (@(posedge SCL_CLK)
		// after an accepted read address the first data bit follows at once
		disable iff (!RESETN) bitcnt == guard_pkg::ACK_SLOT && ack_go
		|-> SDA_OE ##1 (SDA_OE == (state == guard_pkg::S_RDATA &&
		!rd_byte[7])))
		else $error("acknowledge slot not driven");

endmodule : i2c_config_guard
`default_nettype wire

// file: rtl/guard_pkg.sv
// shared constants, types and decode helpers for the serial config port
package guard_pkg;

	// internal pointer values and regions
	localparam logic [7:0] PROT_ADDR = 8'h38; // write-only protection code
	localparam logic [7:0] CFG_LO_LAST = 8'h05; // low config block ends here
	localparam logic [7:0] CFG_HI_FIRST = 8'h30; // high config block start
	localparam logic [7:0] CFG_HI_LAST = 8'h3E; // high config block end
	localparam logic [7:0] MEM_FIRST = 8'h40; // general-purpose memory start
	localparam logic [7:0] LOCK_ADDR = 8'h3E; // byte that holds the lock bit
	localparam int LOCK_BIT = 0; // lock bit position in that byte

	// protection code
	localparam logic [7:0] PROT_RESET = 8'h00; // fully protected
	localparam logic [3:0] UNLOCK_NIB = 4'h5; // per-nibble unlock pattern

	// serial framing
	localparam logic [3:0] LAST_BIT = 4'h7; // eighth data clock
	localparam logic [3:0] ACK_SLOT = 4'h8; // ninth clock, acknowledge
	localparam logic [4:0] PAGE_BYTES = 5'h10; // bytes per page write

	// strap codes and address decode
	localparam logic [1:0] TYPE_PREFIX = 2'h2; // upper device-type bits
	localparam logic [2:0] BUS_MID_OPEN = 3'h3; // middle strap left open
	localparam logic [1:0] LO_OPEN_CODE = 2'h2; // low strap left open
	localparam logic [2:0] SETTLE_CYCLES = 3'h4; // agreement before capture

	// link-side frame states
	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_PTR, S_WDATA, S_RDATA, S_IGNORE
	} link_state_t;

	// commit engine states
	typedef enum logic [0:0] {C_IDLE, C_COPY} commit_state_t;

	// configuration register region, the protection code excluded
	function automatic logic is_cfg(input logic [7:0] a);
		return (a <= CFG_LO_LAST) ||
			(a >= CFG_HI_FIRST && a <= CFG_HI_LAST && a != PROT_ADDR);
	endfunction : is_cfg

	// general-purpose memory region
	function automatic logic is_mem(input logic [7:0] a);
		return a >= MEM_FIRST;
	endfunction : is_mem

	// straps: code bit1 set means open, else bit0 is the level
	function automatic logic [6:0] strap_decode(input logic [1:0] hi,
		input logic [1:0] mid, input logic [1:0] lo);
		logic [3:0] dtype;
		logic [2:0] bus;
		dtype = {TYPE_PREFIX, hi[1] ? 2'h2 : {1'h0, hi[0]}};
		if (mid[1]) begin
			bus = BUS_MID_OPEN;
		end else begin
			bus = {mid[0], lo[1] ? LO_OPEN_CODE : {1'h0, lo[0]}};
		end
		return {dtype, bus};
	endfunction : strap_decode

endpackage : guard_pkg

// file: rtl/store_if.sv
// carrier between the port logic and the byte store
`timescale 1ns/1ps
`default_nettype none
interface store_if;
	logic wr_en; // system-clock write strobe
	logic [7:0] wr_addr; // write pointer
	logic [7:0] wr_data; // write byte
	logic [7:0] rd_addr; // link-side read pointer
	logic [7:0] rd_data; // byte at rd_addr
	logic cfg_lock; // configuration lock bit as stored
	modport store(input wr_en, input wr_addr, input wr_data,
		input rd_addr, output rd_data, output cfg_lock);
	modport user(output wr_en, output wr_addr, output wr_data,
		output rd_addr, input rd_data, input cfg_lock);
endinterface : store_if
`default_nettype wire

// file: rtl/nv_store.sv
// byte store: written on the system clock, read from the link side
`timescale 1ns/1ps
`default_nettype none
module nv_store (
	input wire logic clk,
	input wire logic resetn,
	store_if.store st
);
	logic [7:0] mem [256]; // whole pointer space

	// write port; reset gives defined contents in place of a preload
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 256; i++) begin
				mem[i] <= 8'h00;
			end
		end else if (st.wr_en) begin
			mem[st.wr_addr] <= st.wr_data;
		end
	end

	// read port is static storage; a host must not read a byte mid-commit
	assign st.rd_data = mem[st.rd_addr];
	assign st.cfg_lock = mem[guard_pkg::LOCK_ADDR][guard_pkg::LOCK_BIT];
endmodule : nv_store
`default_nettype wire

// file: rtl/strap_capture.sv
// three-state strap synchroniser and one-time address capture
`timescale 1ns/1ps
`default_nettype none
module strap_capture (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [1:0] sel_hi,
	input wire logic [1:0] sel_mid,
	input wire logic [1:0] sel_lo,
	output logic [6:0] dev_addr,
	output logic addr_valid
);
	logic [5:0] s1, s2, s3; // three-stage pin synchroniser
	logic [2:0] settle; // cycles the strap value has held

	// synchroniser chain
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1 <= 6'h00;
			s2 <= 6'h00;
			s3 <= 6'h00;
		end else begin
			s1 <= {sel_hi, sel_mid, sel_lo};
			s2 <= s1;
			s3 <= s2;
		end
	end

	// count agreement of stages two and three before trusting the straps
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			settle <= 3'h0;
		end else if (s2 != s3) begin
			settle <= 3'h0;
		end else if (settle != guard_pkg::SETTLE_CYCLES) begin
			settle <= settle + 3'h1;
		end
	end

	// capture once; later strap movement is ignored on purpose
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dev_addr <= 7'h00;
			addr_valid <= 1'h0;
		end else if (!addr_valid && settle == guard_pkg::SETTLE_CYCLES) begin
			dev_addr <= guard_pkg::strap_decode(s3[5:4], s3[3:2], s3[1:0]);
			addr_valid <= 1'h1;
		end
	end

	strap_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		addr_valid |=> addr_valid && $stable(dev_addr))
		else $error("captured address moved");
endmodule : strap_capture
`default_nettype wire

// file: bench/host_model.sv
// two-wire bus host model: makes the serial clock, pulls data low
`timescale 1ns/1ps
`default_nettype none
module host_model (
	output logic scl,
	output logic pull,
	input wire logic sda
);
	// clock stands high and data is released between frames
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// one clock period; data moves only while the clock is low
	task automatic clk_bit(input logic drive, output logic seen);
		pull = ~drive;
		#12 scl = 1'b1;
		seen = sda;
		#16 scl = 1'b0;
		#4;
	endtask : clk_bit
	// start or repeated start: data falls with the clock high
	task automatic start();
		pull = 1'b0;
		#12 scl = 1'b1;
		#16 pull = 1'b1;
		#16 scl = 1'b0;
		#4;
	endtask : start
	// stop: data rises with the clock high, then the clock stands still
	task automatic stop();
		pull = 1'b1;
		#12 scl = 1'b1;
		#16 pull = 1'b0;
		#16;
	endtask : stop
	// eight bits, highest first, then sample the target's acknowledge
	task automatic send(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], s);
		clk_bit(1'b1, s);
		ack = ~s;
	endtask : send
	// eight bits from the target, then acknowledge unless last
	task automatic recv(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(1'b1, d[i]);
		clk_bit(last, s);
	endtask : recv
endmodule : host_model
`default_nettype wire

// file: bench/i2c_config_port_write_guard_bench.sv
// self-checking bench for the guarded two-wire configuration port
`timescale 1ns/1ps
`default_nettype none
module i2c_config_port_write_guard_bench;
	logic CLK = 1'b0; // system clock, 40 ns
	logic RESETN = 1'b0; // held low from time zero
	logic WRITE_PROT = 1'b0; // protect pin, active high
	logic [5:0] strap = 6'h26; // strap codes {hi, mid, lo}
	logic scl, pull, sda_out, sda_oe, busy, ready;
	wire logic sda = ~(pull | sda_oe); // pulled-up open-drain wire
	int fails = 0;
	int samples_checked = 0;
	logic [6:0] dev; // bus address in use
	logic [7:0] got [16]; // bytes of the last read
	logic [7:0] mem [256]; // expected store contents
	logic [7:0] code; // protection code last written
	logic busy_seen; // commit seen during the last settle
	// strap rows and the addresses that they must give
	logic [5:0] straps [5] = '{6'h00, 6'h16, 6'h29, 6'h02, 6'h26};
	logic [6:0] addrs [5] = '{7'h40, 7'h4E, 7'h53, 7'h42, 7'h56};
	logic [7:0] codes [5] = '{8'h59, 8'h35, 8'h55, 8'h00, 8'h55};
	always #20 CLK = ~CLK;
	i2c_config_guard DUT (.CLK(CLK), .RESETN(RESETN), .SCL_CLK(scl),
		.SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.WRITE_PROT(WRITE_PROT), .STRAP_SELECT_HI(strap[5:4]),
		.STRAP_SELECT_MID(strap[3:2]), .STRAP_SELECT_LO(strap[1:0]),
		.WRITE_BUSY(busy), .ADDR_READY(ready));
	host_model host (.scl(scl), .pull(pull), .sda(sda));
	////////////////////////////////////////////////////////////////////////
	// verdict, reached from the end of the run or a spent wait
	task automatic conclude();
		if (fails == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	// one comparison
	task automatic check(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			$display("wrong value at %0t: got %h want %h", $time, g, e);
			fails++;
		end
	endtask : check
	// one byte out, acknowledge compared with the expected answer
	task automatic send(input logic [7:0] d, input logic e);
		logic k;
		host.send(d, k);
		check(8'(k), 8'(e));
	endtask : send
	// expected effect of a stored byte; region gates as chosen
	function automatic void model_wr(input logic [7:0] a, input logic [7:0] d);
		if (a == 8'h38)
			code = d;
		else if (a >= 8'h40) begin
			if (code[3:0] == 4'h5 && !WRITE_PROT)
				mem[a] = d;
		end else if (code[7:4] == 4'h5 && !WRITE_PROT && !mem[8'h3E][0])
			mem[a] = d;
	endfunction : model_wr
	// gap after a stop long enough for the commit; busy must end
	task automatic settle();
		busy_seen = 1'b0;
		for (int i = 0; i < 60; i++) begin
			@(posedge CLK);
			busy_seen |= busy;
		end
		check(8'(busy), 8'h00);
	endtask : settle
	////////////////////////////////////////////////////////////////////////
	// write n bytes v, v+1, ... from pointer a
	task automatic wr(input logic [7:0] a, input int n, input logic [7:0] v);
		logic [7:0] p;
		p = a;
		host.start();
		send({dev, 1'b0}, 1'b1);
		send(a, 1'b1);
		for (int i = 0; i < n; i++) begin
			send(v + 8'(i), 1'b1);
			if (i < 16)
				model_wr(p, v + 8'(i));
			p = {p[7:4], p[3:0] + 4'h1};
		end
		host.stop();
		settle();
	endtask : wr
	// pointer write, repeated start, n bytes read
	task automatic rd(input logic [7:0] a, input int n);
		host.start();
		send({dev, 1'b0}, 1'b1);
		send(a, 1'b1);
		host.start();
		send({dev, 1'b1}, 1'b1);
		for (int i = 0; i < n; i++)
			host.recv(i == n - 1, got[i]);
		host.stop();
		settle();
	endtask : rd
	// single write then read back against the model
	task automatic wrchk(input logic [7:0] a, input logic [7:0] v);
		wr(a, 1, v);
		rd(a, 1);
		check(got[0], mem[a]);
	endtask : wrchk
	// reset with given straps, wait for capture, warm the link side
	task automatic do_reset(input logic [5:0] s);
		@(posedge CLK);
		strap <= s;
		RESETN <= 1'b0;
		repeat (10) @(posedge CLK);
		check({6'h00, busy, ready}, 8'h00);
		RESETN <= 1'b1;
		for (int i = 0; i < 50 && ready !== 1'b1; i++)
			@(posedge CLK);
		if (ready !== 1'b1) begin
			fails++;
			conclude();
		end
		repeat (20) @(posedge CLK);
		code = 8'h00;
		foreach (mem[i])
			mem[i] = 8'h00;
		// a foreign type gives clock edges and must go unanswered
		host.start();
		send(8'hFE, 1'b0);
		host.stop();
	endtask : do_reset
	////////////////////////////////////////////////////////////////////////
	// strap rows, then the protection cases
	initial begin
		for (int r = 0; r < 5; r++) begin
			do_reset(straps[r]);
			dev = addrs[r];
			host.start();
			send({dev, 1'b0}, 1'b1);
			host.stop();
			host.start();
			send({dev ^ 7'h01, 1'b0}, 1'b0);
			host.stop();
		end
		check(8'(sda_out), 8'h00);
		wrchk(8'h01, 8'hA5);
		wrchk(8'h40, 8'h5A);
		foreach (codes[c]) begin
			wr(8'h38, 1, codes[c]);
			wrchk(8'h02, codes[c] ^ 8'hF0);
			wrchk(8'h41, codes[c] ^ 8'h0F);
		end
		rd(8'h38, 1);
		check(got[0], 8'h00);
		// seventeen bytes from near the page end: wrap, last dropped
		wr(8'h4E, 17, 8'h10);
		check(8'(busy_seen), 8'h01);
		rd(8'h40, 16);
		for (int i = 0; i < 16; i++)
			check(got[i], mem[8'h40 + 8'(i)]);
		@(posedge CLK);
		WRITE_PROT <= 1'b1;
		wrchk(8'h42, 8'h99);
		wrchk(8'h03, 8'h66);
		WRITE_PROT <= 1'b0;
		wrchk(8'h3E, 8'h01);
		wrchk(8'h03, 8'h77);
		wrchk(8'h3E, 8'h00);
		// straps move after capture; the address must not follow
		strap <= 6'h00;
		repeat (20) @(posedge CLK);
		wrchk(8'h41, 8'hC3);
		conclude();
	end
endmodule : i2c_config_port_write_guard_bench
`default_nettype wire
